// ==== pcs_port_clock.sv ====
// Module: port latches, pin inputs, wakeup and system clock division
`timescale 1ns/1ps
module pcs_port_clock (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Bit port instructions
    input wire logic set_bit_port_instr_in,
    input wire logic reset_bit_port_instr_in,
    input wire logic clear_all_bit_port_instr_in,
    input wire logic skip_bit_port_zero_instr_in,
    input wire logic [pcs_pkg::IDX_W-1:0] bit_index_in,
    output logic skip_out,
    // Nibble port instructions
    input wire logic write_nibble_a_instr_in,
    input wire logic write_nibble_b_instr_in,
    input wire logic read_nibble_a_instr_in,
    input wire logic read_nibble_b_instr_in,
    input wire logic read_input_port_instr_in,
    input wire logic [pcs_pkg::NIB_W-1:0] acc_in,
    output logic [pcs_pkg::NIB_W-1:0] read_data_out,
    output logic read_valid_out,
    // Control registers
    input wire logic pullup_write_in,
    input wire logic keyon_write_in,
    input wire logic mode_write_in,
    input wire logic serial_select_write_in,
    input wire logic [pcs_pkg::NIB_W-1:0] ctrl_data_in,
    output logic [pcs_pkg::NIB_W-1:0] pullup_control_out,
    output logic [pcs_pkg::NIB_W-1:0] keyon_wake_control_out,
    output logic [pcs_pkg::MODE_W-1:0] clock_mode_register_out,
    output logic [pcs_pkg::NIB_W-1:0] serial_pin_select_out,
    // Bit port pins
    input wire logic [pcs_pkg::BIT_PORT_W-1:0] bit_port_pins_in,
    output logic [pcs_pkg::BIT_PORT_W-1:0] bit_port_pins_out,
    output logic [pcs_pkg::BIT_PORT_W-1:0] bit_port_pins_oe_out,
    // Nibble port pins
    input wire logic [pcs_pkg::NIB_W-1:0] nibble_port_a_pins_in,
    input wire logic [pcs_pkg::NIB_W-1:0] nibble_port_b_pins_in,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_a_pins_oe_out,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_b_pins_oe_out,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_a_pullup_out,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_b_pullup_out,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_a_pins_out,
    output logic [pcs_pkg::NIB_W-1:0] nibble_port_b_pins_out,
    // Input port, interrupts, wakeup
    input wire logic [pcs_pkg::IN_PORT_W-1:0] input_port_pins_in,
    input wire logic ext_irq_a_in,
    input wire logic ext_irq_b_in,
    output logic [pcs_pkg::IN_PORT_W-1:0] input_port_level_out,
    output logic ext_irq_a_out,
    output logic ext_irq_b_out,
    output logic keyon_wake_out,
    // Reset pin and clocks
    input wire logic watchdog_reset_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output logic sys_clk_en_out,
    output logic instr_clk_en_out
);
    localparam int IO_W = 2 * pcs_pkg::NIB_W + pcs_pkg::IN_PORT_W + 2 + pcs_pkg::BIT_PORT_W;

    logic [IO_W-1:0] raw_pins;
    logic [IO_W-1:0] sync_pins;
    logic [pcs_pkg::BIT_PORT_W-1:0] bit_sync;
    logic [pcs_pkg::NIB_W-1:0] a_sync;
    logic [pcs_pkg::NIB_W-1:0] b_sync;
    logic [pcs_pkg::IN_PORT_W-1:0] in_sync;
    logic irq_a_sync;
    logic irq_b_sync;

    assign raw_pins = {bit_port_pins_in, ext_irq_b_in, ext_irq_a_in, input_port_pins_in,
                       nibble_port_b_pins_in, nibble_port_a_pins_in};

    pcs_sync #(.WIDTH(IO_W)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .async_in(raw_pins),
        .sync_out(sync_pins)
    );

    assign {bit_sync, irq_b_sync, irq_a_sync, in_sync, b_sync, a_sync} = sync_pins;

    // Wakeup term for one nibble port; a pin held low with its bit set wakes
    function automatic logic nib_wake(input logic [pcs_pkg::NIB_W-1:0] lvl,
                                      input logic [pcs_pkg::NIB_W-1:0] en);
        nib_wake = |(~lvl & en);
    endfunction

    // Port and control state
    logic [pcs_pkg::BIT_PORT_W-1:0] bit_latch_q, bit_latch_d;
    logic [pcs_pkg::NIB_W-1:0] nib_a_q, nib_a_d, nib_b_q, nib_b_d;
    logic [pcs_pkg::NIB_W-1:0] pullup_q, pullup_d, keyon_q, keyon_d, serial_q, serial_d;
    logic [pcs_pkg::MODE_W-1:0] mode_q, mode_d;
    logic skip_q, skip_d;
    logic [pcs_pkg::NIB_W-1:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [pcs_pkg::IN_PORT_W-1:0] in_lvl_q, in_lvl_d;
    logic irq_a_q, irq_a_d, irq_b_q, irq_b_d, wake_q, wake_d, rst_pin_q, rst_pin_d;

    always_comb begin
        bit_latch_d = bit_latch_q;
        if (clear_all_bit_port_instr_in)
            bit_latch_d = '0;
        else if (set_bit_port_instr_in)
            bit_latch_d[bit_index_in] = 1'b1;
        else if (reset_bit_port_instr_in)
            bit_latch_d[bit_index_in] = 1'b0;
        nib_a_d = write_nibble_a_instr_in ? acc_in : nib_a_q;
        nib_b_d = write_nibble_b_instr_in ? acc_in : nib_b_q;
        pullup_d = pullup_write_in ? ctrl_data_in : pullup_q;
        keyon_d = keyon_write_in ? ctrl_data_in : keyon_q;
        serial_d = serial_select_write_in ? ctrl_data_in : serial_q;
        mode_d = mode_write_in ? ctrl_data_in : mode_q;
        // Pin level is tested only, never loaded into the accumulator
        skip_d = skip_bit_port_zero_instr_in & ~bit_sync[bit_index_in];
        rvalid_d = read_nibble_a_instr_in | read_nibble_b_instr_in | read_input_port_instr_in;
        rdata_d = '0;
        if (read_nibble_a_instr_in)
            rdata_d = a_sync;
        else if (read_nibble_b_instr_in)
            rdata_d = b_sync;
        else if (read_input_port_instr_in)
            rdata_d = {1'b0, in_sync};
        in_lvl_d = in_sync;
        irq_a_d = irq_a_sync;
        irq_b_d = irq_b_sync;
        // Wake bit i covers pin i of both nibble ports
        wake_d = nib_wake(a_sync, keyon_q) | nib_wake(b_sync, keyon_q)
                 | irq_a_sync | irq_b_sync;
        rst_pin_d = watchdog_reset_in;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            bit_latch_q <= pcs_pkg::BIT_LATCH_RESET;
            nib_a_q <= pcs_pkg::NIB_LATCH_RESET;
            nib_b_q <= pcs_pkg::NIB_LATCH_RESET;
            pullup_q <= pcs_pkg::CTRL_RESET;
            keyon_q <= pcs_pkg::CTRL_RESET;
            serial_q <= pcs_pkg::CTRL_RESET;
            mode_q <= pcs_pkg::MODE_RESET;
            skip_q <= 1'b0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
            in_lvl_q <= '0;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
            wake_q <= 1'b0;
            rst_pin_q <= 1'b0;
        end else begin
            bit_latch_q <= bit_latch_d;
            nib_a_q <= nib_a_d;
            nib_b_q <= nib_b_d;
            pullup_q <= pullup_d;
            keyon_q <= keyon_d;
            serial_q <= serial_d;
            mode_q <= mode_d;
            skip_q <= skip_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            in_lvl_q <= in_lvl_d;
            irq_a_q <= irq_a_d;
            irq_b_q <= irq_b_d;
            wake_q <= wake_d;
            rst_pin_q <= rst_pin_d;
        end
    end

    // Clock divider: system enable then divide by three
    logic half_q, half_d, sys_en_q, sys_en_d, ins_en_q, ins_en_d;
    logic [1:0] div3_q, div3_d;
    logic sys_tick;

    always_comb begin
        half_d = ~half_q;
        // Bit 3 set halves the oscillator rate
        sys_tick = mode_q[pcs_pkg::SYSCLK_HALVE_BIT] ? half_q : 1'b1;
        sys_en_d = sys_tick;
        div3_d = div3_q;
        ins_en_d = 1'b0;
        if (sys_tick) begin
            if (div3_q == 2'(pcs_pkg::INSTR_DIV - 1)) begin
                div3_d = '0;
                ins_en_d = 1'b1;
            end else begin
                div3_d = div3_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            half_q <= 1'b0;
            sys_en_q <= 1'b0;
            ins_en_q <= 1'b0;
            div3_q <= '0;
        end else begin
            half_q <= half_d;
            sys_en_q <= sys_en_d;
            ins_en_q <= ins_en_d;
            div3_q <= div3_d;
        end
    end

    // Open-drain: data always low, enable when latch holds zero
    assign bit_port_pins_out = '0;
    assign bit_port_pins_oe_out = ~bit_latch_q;
    assign nibble_port_a_pins_out = '0;
    assign nibble_port_b_pins_out = '0;
    assign nibble_port_a_pins_oe_out = ~nib_a_q;
    assign nibble_port_b_pins_oe_out = ~nib_b_q;
    assign nibble_port_a_pullup_out = pullup_q;
    assign nibble_port_b_pullup_out = pullup_q;
    assign pullup_control_out = pullup_q;
    assign keyon_wake_control_out = keyon_q;
    assign clock_mode_register_out = mode_q;
    assign serial_pin_select_out = serial_q;
    assign skip_out = skip_q;
    assign read_data_out = rdata_q;
    assign read_valid_out = rvalid_q;
    assign input_port_level_out = in_lvl_q;
    assign ext_irq_a_out = irq_a_q;
    assign ext_irq_b_out = irq_b_q;
    assign keyon_wake_out = wake_q;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = rst_pin_q;
    assign sys_clk_en_out = sys_en_q;
    assign instr_clk_en_out = ins_en_q;
endmodule // pcs_port_clock

// ==== pcs_pkg.sv ====
// Package: constants for the port and clock select block
// Operation
// - Each bit-port pin has its own separately writable output latch.
// - Bit-port pin level is offered only as a skip condition.
// - Two 4-bit ports written and read as nibbles; latch one means input.
// - Output ports only pull low; latch one leaves the pin undriven.
// - Control bits enable pull-up and key-on wakeup; bit i serves pin i of both nibble ports.
// - Pull-up bit one turns pull-up on; wakeup bit zero disables wakeup.
// - After reset all open-drain pins stay released until a zero is written.
// - A 3-bit input port shares pins with serial clock, out and in.
// - The 3-bit port stays readable while serial functions use its pins.
// - Clock mode bit 3 selects oscillator rate (0) or half rate (1).
// - Half rate is selected whenever reset is left.
// - The instruction clock is the system clock divided by three.
// - One instruction clock period is one machine cycle.
// - The reset pin is pulled low on a watchdog reset.
// - Two interrupt pins give interrupt requests and back-up wakeup.
package pcs_pkg;
    localparam int BIT_PORT_W = 8;
    localparam int NIB_W = 4;
    localparam int IN_PORT_W = 3;
    localparam int MODE_W = 4;
    localparam int SYSCLK_HALVE_BIT = 3;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h8;
    localparam logic [BIT_PORT_W-1:0] BIT_LATCH_RESET = 8'hff;
    localparam logic [NIB_W-1:0] NIB_LATCH_RESET = 4'hf;
    localparam logic [NIB_W-1:0] CTRL_RESET = 4'h0;
    localparam int SYNC_STAGES = 2;
    localparam int INSTR_DIV = 3;
    localparam int IDX_W = 3;
endpackage

// ==== pcs_sync.sv ====
// Module: two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pcs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // First stage feeds only the second
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // pcs_sync

// ==== pcs_asserts.sv ====
// Checker: port-level properties of the port and clock select block
`timescale 1ns/1ps
module pcs_chk (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Instructions
    input wire logic set_bit_port_instr_in,
    input wire logic reset_bit_port_instr_in,
    input wire logic clear_all_bit_port_instr_in,
    input wire logic skip_bit_port_zero_instr_in,
    input wire logic [2:0] bit_index_in,
    input wire logic write_nibble_a_instr_in,
    input wire logic read_nibble_a_instr_in,
    input wire logic read_nibble_b_instr_in,
    input wire logic read_input_port_instr_in,
    input wire logic [3:0] acc_in,
    input wire logic watchdog_reset_in,
    // Pins and results
    input wire logic [3:0] nibble_port_a_pins_in,
    input wire logic [2:0] input_port_pins_in,
    input wire logic skip_out,
    input wire logic [3:0] read_data_out,
    input wire logic read_valid_out,
    input wire logic [7:0] bit_port_pins_oe_out,
    input wire logic [3:0] nibble_port_a_pins_oe_out,
    input wire logic reset_pin_oe_out,
    input wire logic sys_clk_en_out,
    input wire logic instr_clk_en_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [1:0] tick_q, tick_d;
    logic seen_q, seen_d;
    // First instruction tick after reset has no reference, so it is skipped
    always_comb begin
        tick_d = instr_clk_en_out ? 2'h0 : tick_q + 2'(sys_clk_en_out);
        seen_d = seen_q | instr_clk_en_out;
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tick_q <= 2'h0;
            seen_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            seen_q <= seen_d;
        end
    end
    a_bit_drive_low: assert property (
        reset_bit_port_instr_in && !set_bit_port_instr_in && !clear_all_bit_port_instr_in
        |=> bit_port_pins_oe_out[$past(bit_index_in)]) else $error("bit latch clear missed");
    a_bit_release: assert property (
        set_bit_port_instr_in && !clear_all_bit_port_instr_in
        |=> !bit_port_pins_oe_out[$past(bit_index_in)]) else $error("bit latch set missed");
    a_clear_all: assert property (
        clear_all_bit_port_instr_in |=> &bit_port_pins_oe_out) else $error("clear all missed");
    a_nibble_write: assert property (write_nibble_a_instr_in
        |=> nibble_port_a_pins_oe_out == ~$past(acc_in)) else $error("nibble a write wrong");
    a_skip_cause: assert property (skip_out |-> $past(skip_bit_port_zero_instr_in))
        else $error("skip without test");
    a_read_nibble: assert property (read_nibble_a_instr_in |=> read_valid_out &&
        read_data_out == $past(nibble_port_a_pins_in, 3)) else $error("nibble a read wrong");
    a_read_input: assert property (read_input_port_instr_in &&
        !read_nibble_a_instr_in && !read_nibble_b_instr_in
        |=> read_data_out == {1'b0, $past(input_port_pins_in, 3)})
        else $error("input port read wrong");
    a_instr_div: assert property (instr_clk_en_out && seen_q |-> sys_clk_en_out &&
        tick_q == 2'h2) else $error("instruction clock not every third tick");
    a_wdog_pin: assert property (watchdog_reset_in |=> reset_pin_oe_out)
        else $error("reset pin not pulled low");
    c_skip: cover property (skip_out);
    c_read: cover property (read_valid_out);
    c_instr: cover property (instr_clk_en_out && seen_q);
endmodule // pcs_chk
bind pcs_port_clock pcs_chk i_pcs_chk (.*);

// ==== pcs_board.sv ====
// Board model: LEDs on the bit port, keys and pull-ups on the nibble ports
`timescale 1ns/1ps
module pcs_board (
    // Drive enables from the device
    input wire logic [7:0] bit_oe_in,
    input wire logic [3:0] a_oe_in,
    input wire logic [3:0] b_oe_in,
    input wire logic [3:0] a_pu_in,
    input wire logic [3:0] b_pu_in,
    // Pressed keys ground their pins
    input wire logic [3:0] a_key_in,
    input wire logic [3:0] b_key_in,
    // Pin levels
    output logic [7:0] bit_lvl_out,
    output logic [3:0] a_lvl_out,
    output logic [3:0] b_lvl_out
);
    // LED loads act as pull-ups on the bit port
    assign bit_lvl_out = ~bit_oe_in;
    // Without the pull-up a released pin leaks low on this board
    assign a_lvl_out = ~a_oe_in & ~a_key_in & a_pu_in;
    assign b_lvl_out = ~b_oe_in & ~b_key_in & b_pu_in;
endmodule // pcs_board

// ==== testbench.sv ====
// Testbench: self-checking bench for the port and clock select block
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in, rst_in, set_bit_port_instr_in, reset_bit_port_instr_in, skip_out;
    logic clear_all_bit_port_instr_in, skip_bit_port_zero_instr_in, read_valid_out;
    logic write_nibble_a_instr_in, write_nibble_b_instr_in, read_nibble_a_instr_in;
    logic read_nibble_b_instr_in, read_input_port_instr_in, pullup_write_in, keyon_write_in;
    logic mode_write_in, serial_select_write_in, ext_irq_a_in, ext_irq_b_in, ext_irq_a_out;
    logic ext_irq_b_out, keyon_wake_out, watchdog_reset_in, reset_pin_out, reset_pin_oe_out;
    logic sys_clk_en_out, instr_clk_en_out;
    logic [2:0] bit_index_in, input_port_pins_in, input_port_level_out;
    logic [3:0] acc_in, read_data_out, ctrl_data_in, pullup_control_out, keyon_wake_control_out;
    logic [3:0] clock_mode_register_out, serial_pin_select_out, key_a, key_b;
    logic [3:0] nibble_port_a_pins_in, nibble_port_b_pins_in, nibble_port_a_pins_oe_out;
    logic [3:0] nibble_port_b_pins_oe_out, nibble_port_a_pullup_out, nibble_port_b_pullup_out;
    logic [3:0] nibble_port_a_pins_out, nibble_port_b_pins_out;
    logic [7:0] bit_port_pins_in, bit_port_pins_out, bit_port_pins_oe_out;
    int fails, samples_checked, cycles, s, n;
    // Row: op, argument, bit-port oe, port a oe, port b oe
    logic [23:0] rows [8] = '{24'h000100, 24'h078100, 24'h108000, 24'h20ff00,
        24'h13f700, 24'h35f7a0, 24'h4cf7a3, 24'h3ff703};
    pcs_port_clock i_pcs_port_clock (.*);
    pcs_board i_pcs_board (.bit_oe_in(bit_port_pins_oe_out), .a_oe_in(nibble_port_a_pins_oe_out),
        .b_oe_in(nibble_port_b_pins_oe_out), .a_pu_in(nibble_port_a_pullup_out),
        .b_pu_in(nibble_port_b_pullup_out), .a_key_in(key_a), .b_key_in(key_b),
        .bit_lvl_out(bit_port_pins_in), .a_lvl_out(nibble_port_a_pins_in),
        .b_lvl_out(nibble_port_b_pins_in));
    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Op 4'hf is idle; one op per cycle keeps every pulse single
    task automatic drive(input logic [3:0] op, input logic [3:0] arg);
        reset_bit_port_instr_in <= op == 4'h0;
        set_bit_port_instr_in <= op == 4'h1;
        clear_all_bit_port_instr_in <= op == 4'h2;
        write_nibble_a_instr_in <= op == 4'h3;
        write_nibble_b_instr_in <= op == 4'h4;
        read_nibble_a_instr_in <= op == 4'h5;
        read_nibble_b_instr_in <= op == 4'h6;
        read_input_port_instr_in <= op == 4'h7;
        skip_bit_port_zero_instr_in <= op == 4'h8;
        pullup_write_in <= op == 4'h9;
        keyon_write_in <= op == 4'ha;
        mode_write_in <= op == 4'hb;
        serial_select_write_in <= op == 4'hc;
        bit_index_in <= arg[2:0];
        acc_in <= arg;
        ctrl_data_in <= arg;
    endtask
    task automatic step(input logic [3:0] op, input logic [3:0] arg);
        @(posedge clk_sys_in) drive(op, arg);
        @(posedge clk_sys_in) drive(4'hf, 4'h0);
        #1;
    endtask
    task automatic count();
        s = 0;
        n = 0;
        repeat (12) begin
            @(posedge clk_sys_in) #1;
            s += int'(sys_clk_en_out);
            n += int'(instr_clk_en_out);
        end
    endtask
    task automatic chk_reset();
        chk("bit oe", 8'h00, bit_port_pins_oe_out);
        chk("nib oe", 8'h00,
            {nibble_port_a_pins_oe_out, nibble_port_b_pins_oe_out});
        chk("mode", 8'h08, 8'(clock_mode_register_out));
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        rst_in = 1'b1;
        {key_a, key_b, input_port_pins_in, ext_irq_a_in, ext_irq_b_in, watchdog_reset_in} = '0;
        drive(4'hf, 4'h0);
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        chk_reset();
        chk("ctrl", 8'h00, {pullup_control_out, keyon_wake_control_out});
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk_sys_in) drive(i < 8 ? rows[i][23:20] : 4'hf, rows[i % 8][19:16]);
            if (i > 0) begin
                #1;
                chk("bit oe", rows[i-1][15:8], bit_port_pins_oe_out);
                chk("nib oe", rows[i-1][7:0],
                    {nibble_port_a_pins_oe_out, nibble_port_b_pins_oe_out});
            end
        end
        chk("low drive", 8'h00, bit_port_pins_out);
        chk("nib drive", 8'h00, {nibble_port_a_pins_out, nibble_port_b_pins_out});
        step(4'h4, 4'hc);
        chk("rewrite", 8'h03,
            {nibble_port_a_pins_oe_out, nibble_port_b_pins_oe_out});
        repeat (3) @(posedge clk_sys_in);
        step(4'h8, 4'h2);
        chk("skip", 8'h01, 8'(skip_out));
        step(4'h8, 4'h3);
        chk("skip", 8'h00, 8'(skip_out));
        step(4'h9, 4'hf);
        chk("pullup", 8'hff, {nibble_port_a_pullup_out, nibble_port_b_pullup_out});
        @(posedge clk_sys_in);
        key_a <= 4'h6;
        input_port_pins_in <= 3'h5;
        repeat (4) @(posedge clk_sys_in);
        step(4'h5, 4'h0);
        chk("read a", 8'h19, {3'h0, read_valid_out, read_data_out});
        step(4'h6, 4'h0);
        chk("read b", 8'h1c, {3'h0, read_valid_out, read_data_out});
        step(4'hc, 4'h7);
        chk("serial sel", 8'h07, 8'(serial_pin_select_out));
        step(4'h7, 4'h0);
        chk("read in", 8'h15, {3'h0, read_valid_out, read_data_out});
        chk("in level", 8'h05, 8'(input_port_level_out));
        chk("wake off", 8'h00, 8'(keyon_wake_out));
        step(4'ha, 4'h3);
        chk("keyon ctrl", 8'h03, 8'(keyon_wake_control_out));
        repeat (4) @(posedge clk_sys_in) #1;
        chk("wake key", 8'h01, 8'(keyon_wake_out));
        step(4'ha, 4'h0);
        @(posedge clk_sys_in);
        key_a <= 4'h0;
        {ext_irq_a_in, ext_irq_b_in, watchdog_reset_in} <= 3'h7;
        repeat (4) @(posedge clk_sys_in) #1;
        chk("irq wake", 8'h07, {5'h0, ext_irq_a_out, ext_irq_b_out, keyon_wake_out});
        chk("reset pin", 8'h01, {6'h0, reset_pin_out, reset_pin_oe_out});
        @(posedge clk_sys_in);
        {ext_irq_a_in, ext_irq_b_in, watchdog_reset_in} <= 3'h0;
        count();
        chk("half ticks", 8'h62, 8'({s[3:0], n[3:0]}));
        step(4'hb, 4'h0);
        repeat (4) @(posedge clk_sys_in);
        count();
        chk("full ticks", 8'hc4, 8'({s[3:0], n[3:0]}));
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        chk_reset();
        summarize();
    end
endmodule // testbench
